/* common/cag_pkg.sv */
// package: constants and types for the cpu address generator
package cag_pkg;

    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;

    // branch target kinds
    typedef enum logic [2:0] {
        CAG_BR_NONE,
        CAG_BR_REL8,
        CAG_BR_REL16,
        CAG_BR_IMM20,
        CAG_BR_IMM16,
        CAG_BR_TABLE,
        CAG_BR_REGIND
    } cag_br_kind_t;

    // instruction classes seen by the generator
    typedef enum logic [1:0] {
        CAG_CLS_OTHER,
        CAG_CLS_BRANCH,
        CAG_CLS_CALL
    } cag_cls_t;

    // data operand kinds
    typedef enum logic [2:0] {
        CAG_OP_NONE,
        CAG_OP_IMPLIED,
        CAG_OP_REG8,
        CAG_OP_REG16,
        CAG_OP_DIRECT,
        CAG_OP_DIRECT_SEG,
        CAG_OP_SHORT,
        CAG_OP_SHORT_WORD
    } cag_op_kind_t;

    typedef struct packed {
        cag_cls_t           cls;
        cag_br_kind_t       br_kind;
        logic [19:0]        imm20;
        logic [15:0]        disp;
        logic [4:0]         tbl_idx;
        logic [1:0]         pair_sel;
    } cag_br_req_t;

    typedef struct packed {
        cag_op_kind_t       kind;
        logic               is_unsigned_mul;
        logic [2:0]         reg_sel;
        logic [1:0]         pair_sel;
        logic [15:0]        addr16;
        logic [7:0]         short_byte;
    } cag_op_req_t;

    localparam logic [19:0] CAG_PC_RESET    = 20'h00000;
    localparam logic [3:0]  CAG_UPPER_ZERO  = 4'h0;
    localparam logic [3:0]  CAG_UPPER_F     = 4'hF;
    localparam logic [19:0] CAG_TBL_BASE    = 20'h00080;
    localparam logic [19:0] CAG_TBL_LAST    = 20'h000BF;
    localparam logic [19:0] CAG_SHORT_BASE  = 20'hFFE20;
    localparam logic [19:0] CAG_SHORT_LAST  = 20'hFFF1F;
    localparam logic [7:0]  CAG_SHORT_SPLIT = 8'h20;
    localparam logic [19:0] CAG_SHORT_HI    = 20'hFFF00;
    localparam logic [19:0] CAG_SHORT_LO    = 20'hFFE00;
    localparam logic [1:0]  CAG_PAIR_ACC    = 2'h0;
    localparam logic [2:0]  CAG_REG_X       = 3'h0;

endpackage : cag_pkg

/* logic/cag_addr_gen.sv */
// cpu address generator: branch targets and data operand addresses
`timescale 1ns/100ps

module cag_addr_gen
    import cag_pkg::*;
(
    // clock and reset
    input  wire logic               CLK,
    input  wire logic               SYS_RST,
    // branch request from decoder
    input  wire logic               BR_VALID,
    input  wire cag_br_req_t        BR_REQ,
    input  wire logic [19:0]        NEXT_PC,
    input  wire logic [3:0]         CODE_SEG,
    // table fetch port toward memory
    output logic                    TBL_RD,
    output logic [19:0]             TBL_ADDR,
    input  wire logic               TBL_ACK,
    input  wire logic [15:0]        TBL_DATA,
    // program counter result
    output logic [19:0]             PC,
    output logic                    PC_LOAD,
    output logic                    BR_ILLEGAL,
    output logic                    BR_BUSY,
    // data operand request
    input  wire logic               OP_VALID,
    input  wire cag_op_req_t        OP_REQ,
    input  wire logic [3:0]         EXTRA_SEG,
    // general register file
    input  wire logic [63:0]        REG_FILE,
    // operand result
    output logic [19:0]             OP_ADDR,
    output logic                    OP_ADDR_VALID,
    output logic [15:0]             OP_REG_VAL,
    output logic                    OP_REG_VALID,
    output logic                    OP_ILLEGAL
);

    typedef enum logic [1:0] {CAG_ST_IDLE, CAG_ST_FETCH} cag_state_t;

    cag_state_t     state_r;
    logic [19:0]    pc_r;
    logic           pc_load_r;
    logic           br_ill_r;
    logic [19:0]    tbl_addr_r;
    logic [19:0]    pc_nxt;
    logic           direct_ok;
    logic [15:0]    pair_val [4];
    logic [7:0]     reg_val [8];

    // =======================================================
    // register file views
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_reg
            assign reg_val[gi] = REG_FILE[gi*8 +: 8];
        end
        for (gi = 0; gi < 4; gi++)
        begin : g_pair
            assign pair_val[gi] = REG_FILE[gi*16 +: 16];
        end
    endgenerate

    // =======================================================
    // branch target formation
    always_comb
    begin
        pc_nxt    = pc_r;
        direct_ok = 1'b0;
        case (BR_REQ.br_kind)
            CAG_BR_REL8:
            begin
                // carry past bit 19 wraps
                pc_nxt    = NEXT_PC + {{12{BR_REQ.disp[7]}}, BR_REQ.disp[7:0]};
                direct_ok = (BR_REQ.cls == CAG_CLS_BRANCH);
            end
            CAG_BR_REL16:
            begin
                pc_nxt    = NEXT_PC + {{4{BR_REQ.disp[15]}}, BR_REQ.disp};
                direct_ok = (BR_REQ.cls == CAG_CLS_BRANCH);
            end
            CAG_BR_IMM20:
            begin
                pc_nxt    = BR_REQ.imm20;
                direct_ok = (BR_REQ.cls != CAG_CLS_OTHER);
            end
            CAG_BR_IMM16:
            begin
                pc_nxt    = {CAG_UPPER_ZERO, BR_REQ.imm20[15:0]};
                direct_ok = (BR_REQ.cls != CAG_CLS_OTHER);
            end
            CAG_BR_REGIND:
            begin
                pc_nxt    = {CODE_SEG, pair_val[BR_REQ.pair_sel]};
                direct_ok = (BR_REQ.cls == CAG_CLS_CALL)
                         || (BR_REQ.cls == CAG_CLS_BRANCH
                             && BR_REQ.pair_sel == CAG_PAIR_ACC);
            end
            default:
            begin
                pc_nxt    = pc_r;
                direct_ok = 1'b0;
            end
        endcase
    end

    // =======================================================
    // pc and table fetch sequencing
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state_r    <= CAG_ST_IDLE;
            pc_r       <= CAG_PC_RESET;
            pc_load_r  <= 1'b0;
            br_ill_r   <= 1'b0;
            tbl_addr_r <= CAG_TBL_BASE;
        end
        else
        begin
            pc_load_r <= 1'b0;
            br_ill_r  <= 1'b0;
            case (state_r)
                CAG_ST_IDLE:
                begin
                    if (BR_VALID)
                    begin
                        if (BR_REQ.br_kind == CAG_BR_TABLE)
                        begin
                            if (BR_REQ.cls == CAG_CLS_CALL)
                            begin
                                // each entry is two bytes
                                tbl_addr_r <= CAG_TBL_BASE
                                    + {14'h0000, BR_REQ.tbl_idx, 1'b0};
                                state_r    <= CAG_ST_FETCH;
                            end
                            else
                            begin
                                br_ill_r <= 1'b1;
                            end
                        end
                        else if (direct_ok)
                        begin
                            pc_r      <= pc_nxt;
                            pc_load_r <= 1'b1;
                        end
                        else
                        begin
                            br_ill_r <= 1'b1;
                        end
                    end
                end
                CAG_ST_FETCH:
                begin
                    if (TBL_ACK)
                    begin
                        pc_r      <= {CAG_UPPER_ZERO, TBL_DATA};
                        pc_load_r <= 1'b1;
                        state_r   <= CAG_ST_IDLE;
                    end
                end
                default:
                begin
                    state_r <= CAG_ST_IDLE;
                end
            endcase
        end
    end

    assign TBL_RD     = (state_r == CAG_ST_FETCH);
    assign TBL_ADDR   = tbl_addr_r;
    assign PC         = pc_r;
    assign PC_LOAD    = pc_load_r;
    assign BR_ILLEGAL = br_ill_r;
    assign BR_BUSY    = (state_r == CAG_ST_FETCH);

    // =======================================================
    // data operand addressing
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            OP_ADDR       <= CAG_PC_RESET;
            OP_ADDR_VALID <= 1'b0;
            OP_REG_VAL    <= 16'h0000;
            OP_REG_VALID  <= 1'b0;
            OP_ILLEGAL    <= 1'b0;
        end
        else
        begin
            OP_ADDR_VALID <= 1'b0;
            OP_REG_VALID  <= 1'b0;
            OP_ILLEGAL    <= 1'b0;
            if (OP_VALID)
            begin
                case (OP_REQ.kind)
                    CAG_OP_IMPLIED:
                    begin
                        // only the unsigned multiply reads X implicitly
                        if (OP_REQ.is_unsigned_mul)
                        begin
                            OP_REG_VAL   <= {8'h00, reg_val[CAG_REG_X]};
                            OP_REG_VALID <= 1'b1;
                        end
                        else
                        begin
                            OP_ILLEGAL <= 1'b1;
                        end
                    end
                    CAG_OP_REG8:
                    begin
                        OP_REG_VAL   <= {8'h00, reg_val[OP_REQ.reg_sel]};
                        OP_REG_VALID <= 1'b1;
                    end
                    CAG_OP_REG16:
                    begin
                        OP_REG_VAL   <= pair_val[OP_REQ.pair_sel];
                        OP_REG_VALID <= 1'b1;
                    end
                    CAG_OP_DIRECT:
                    begin
                        OP_ADDR       <= {CAG_UPPER_F, OP_REQ.addr16};
                        OP_ADDR_VALID <= 1'b1;
                    end
                    CAG_OP_DIRECT_SEG:
                    begin
                        OP_ADDR       <= {EXTRA_SEG, OP_REQ.addr16};
                        OP_ADDR_VALID <= 1'b1;
                    end
                    CAG_OP_SHORT, CAG_OP_SHORT_WORD:
                    begin
                        // low byte 20H..FFH lands in FFE20H.., 00H..1FH in FFF00H..
                        OP_ADDR <= (OP_REQ.short_byte >= CAG_SHORT_SPLIT)
                            ? (CAG_SHORT_LO | {12'h000, OP_REQ.short_byte})
                            : (CAG_SHORT_HI | {12'h000, OP_REQ.short_byte});
                        OP_ADDR_VALID <= 1'b1;
                    end
                    default:
                    begin
                        OP_ILLEGAL <= 1'b1;
                    end
                endcase
            end
        end
    end

    // =======================================================
    // checks
    a_rel_target: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_r == CAG_ST_IDLE && BR_VALID && BR_REQ.br_kind == CAG_BR_REL8
         && BR_REQ.cls == CAG_CLS_BRANCH)
        |=> PC_LOAD && PC == $past(NEXT_PC) + {{12{$past(BR_REQ.disp[7])}},
                                           $past(BR_REQ.disp[7:0])})
        else $error("relative target wrong");
    a_rel_class_only: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_r == CAG_ST_IDLE && BR_VALID && BR_REQ.br_kind == CAG_BR_REL16
         && BR_REQ.cls != CAG_CLS_BRANCH) |=> BR_ILLEGAL && !PC_LOAD)
        else $error("relative used outside branch");
    a_imm16_upper: assert property (@(posedge CLK) disable iff (SYS_RST)
        PC_LOAD && $past(BR_REQ.br_kind) == CAG_BR_IMM16
        && $past(state_r) == CAG_ST_IDLE |-> PC[19:16] == CAG_UPPER_ZERO)
        else $error("short immediate upper nibble set");
    a_tbl_range: assert property (@(posedge CLK) disable iff (SYS_RST)
        TBL_RD |-> TBL_ADDR >= CAG_TBL_BASE && TBL_ADDR < CAG_TBL_LAST
                   && !TBL_ADDR[0])
        else $error("table address out of area");
    a_tbl_pc_64k: assert property (@(posedge CLK) disable iff (SYS_RST)
        TBL_RD && TBL_ACK |=> PC_LOAD && PC == {CAG_UPPER_ZERO, $past(TBL_DATA)})
        else $error("table target wrong");
    a_regind_seg: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_r == CAG_ST_IDLE && BR_VALID && BR_REQ.br_kind == CAG_BR_REGIND
         && BR_REQ.cls == CAG_CLS_BRANCH && BR_REQ.pair_sel != CAG_PAIR_ACC)
        |=> BR_ILLEGAL)
        else $error("branch via non accumulator pair accepted");
    a_direct_upper: assert property (@(posedge CLK) disable iff (SYS_RST)
        OP_VALID && OP_REQ.kind == CAG_OP_DIRECT
        |=> OP_ADDR_VALID && OP_ADDR[19:16] == CAG_UPPER_F)
        else $error("direct upper nibble not F");
    a_short_window: assert property (@(posedge CLK) disable iff (SYS_RST)
        OP_VALID && OP_REQ.kind == CAG_OP_SHORT
        |=> OP_ADDR >= CAG_SHORT_BASE && OP_ADDR <= CAG_SHORT_LAST
            && OP_ADDR[7:0] == $past(OP_REQ.short_byte))
        else $error("short direct outside window");
    a_extra_upper: assert property (@(posedge CLK) disable iff (SYS_RST)
        OP_VALID && OP_REQ.kind == CAG_OP_DIRECT_SEG
        |=> OP_ADDR == {$past(EXTRA_SEG), $past(OP_REQ.addr16)})
        else $error("extra segment address wrong");

endmodule : cag_addr_gen

/* tb/cag_tbl_mem.sv */
// partner model: call table memory answering the generator's fetch port
`timescale 1ns/100ps

// ==========================================
// table memory with programmable answer delay
module cag_tbl_mem
    import cag_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // fetch port
    input  wire logic        TBL_RD,
    input  wire logic [19:0] TBL_ADDR,
    output logic             TBL_ACK,
    output logic [15:0]      TBL_DATA,
    // answer delay in cycles
    input  wire logic [3:0]  DELAY
);

    logic [3:0] wait_r;

    always_ff @(posedge CLK)
    begin
        if (SYS_RST || !TBL_RD || TBL_ACK)
        begin
            wait_r  <= 4'h0;
            TBL_ACK <= 1'b0;
        end
        else if (wait_r == DELAY)
            TBL_ACK <= 1'b1;
        else
            wait_r <= wait_r + 4'h1;
    end

    // outside an answer the data toggles, so a stale value never matches
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            TBL_DATA <= 16'h5A5A;
        else if (TBL_RD && !TBL_ACK && wait_r == DELAY)
            TBL_DATA <= {TBL_ADDR[7:0] ^ 8'hA5, TBL_ADDR[7:0]};
        else
            TBL_DATA <= ~TBL_DATA;
    end

endmodule : cag_tbl_mem

/* tb/testbench.sv */
// testbench: directed scenarios for the cpu address generator
`timescale 1ns/100ps

// ==========================================
// bench top
module testbench
    import cag_pkg::*;
;
    logic        clk, sys_rst, br_valid, tbl_rd, tbl_ack, pc_load, br_illegal, br_busy;
    logic        op_valid, op_addr_valid, op_reg_valid, op_illegal;
    cag_br_req_t br_req;
    cag_op_req_t op_req;
    logic [19:0] next_pc, tbl_addr, pc, op_addr;
    logic [3:0]  code_seg, extra_seg, mem_delay;
    logic [15:0] tbl_data, op_reg_val;
    logic [63:0] reg_file;
    int          err_count, comparisons, cycles;

    cag_addr_gen DUT (.CLK(clk), .SYS_RST(sys_rst), .BR_VALID(br_valid), .BR_REQ(br_req),
        .NEXT_PC(next_pc), .CODE_SEG(code_seg), .TBL_RD(tbl_rd), .TBL_ADDR(tbl_addr),
        .TBL_ACK(tbl_ack), .TBL_DATA(tbl_data), .PC(pc), .PC_LOAD(pc_load),
        .BR_ILLEGAL(br_illegal), .BR_BUSY(br_busy), .OP_VALID(op_valid), .OP_REQ(op_req),
        .EXTRA_SEG(extra_seg), .REG_FILE(reg_file), .OP_ADDR(op_addr),
        .OP_ADDR_VALID(op_addr_valid), .OP_REG_VAL(op_reg_val),
        .OP_REG_VALID(op_reg_valid), .OP_ILLEGAL(op_illegal));

    cag_tbl_mem MEM (.CLK(clk), .SYS_RST(sys_rst), .TBL_RD(tbl_rd), .TBL_ADDR(tbl_addr),
        .TBL_ACK(tbl_ack), .TBL_DATA(tbl_data), .DELAY(mem_delay));

    always #12.5 clk = ~clk;

    // ==========================================
    // shared tasks
    task automatic wrap_up;
        if (err_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic do_br(input cag_br_req_t r, input logic [19:0] exp, input logic ill,
                         input logic [19:0] exp_ta);
        int n;
        @(posedge clk); #2;
        br_valid = 1'b1;
        br_req   = r;
        @(posedge clk); #2;
        br_valid = 1'b0;
        n = 0;
        chk(tbl_rd, exp_ta != 20'h0);
        if (exp_ta != 20'h0)
        begin
            chk(tbl_addr, exp_ta);
            chk(br_busy, 1'b1);
        end
        while (tbl_rd === 1'b1 && n < 20)
        begin
            @(posedge clk); #2;
            n++;
        end
        chk(br_busy, 1'b0);
        chk(br_illegal, ill);
        chk(pc_load, !ill);
        if (!ill)
            chk(pc, exp);
    endtask : do_br

    task automatic do_op(input cag_op_req_t r);
        @(posedge clk); #2;
        op_valid = 1'b1;
        op_req   = r;
        @(posedge clk); #2;
        op_valid = 1'b0;
    endtask : do_op

    task automatic do_addr(input cag_op_kind_t k, input logic [15:0] a,
                           input logic [7:0] s, input logic [19:0] exp);
        do_op('{k, 1'b0, 3'h0, 2'h0, a, s});
        chk(op_addr_valid, 1'b1);
        chk(op_addr, exp);
    endtask : do_addr

    // ==========================================
    // scenarios
    task automatic t_relative;
        next_pc = 20'h00010;
        do_br('{CAG_CLS_BRANCH, CAG_BR_REL8, 20'h0, 16'hFF80, 5'h0, 2'h0}, 20'hFFF90, 0, 0);
        next_pc = 20'h12345;
        do_br('{CAG_CLS_BRANCH, CAG_BR_REL8, 20'h0, 16'h007F, 5'h0, 2'h0}, 20'h123C4, 0, 0);
        next_pc = 20'hFFFF0;
        do_br('{CAG_CLS_BRANCH, CAG_BR_REL16, 20'h0, 16'h7FFF, 5'h0, 2'h0}, 20'h07FEF, 0, 0);
        do_br('{CAG_CLS_CALL, CAG_BR_REL8, 20'h0, 16'h0004, 5'h0, 2'h0}, 0, 1, 0);
        do_br('{CAG_CLS_OTHER, CAG_BR_REL16, 20'h0, 16'h0004, 5'h0, 2'h0}, 0, 1, 0);
        do_br('{CAG_CLS_BRANCH, CAG_BR_NONE, 20'h0, 16'h0004, 5'h0, 2'h0}, 0, 1, 0);
    endtask : t_relative

    task automatic t_immediate;
        do_br('{CAG_CLS_CALL, CAG_BR_IMM20, 20'hABCDE, 16'h0, 5'h0, 2'h0}, 20'hABCDE, 0, 0);
        do_br('{CAG_CLS_BRANCH, CAG_BR_IMM20, 20'h1357A, 16'h0, 5'h0, 2'h0}, 20'h1357A, 0, 0);
        do_br('{CAG_CLS_BRANCH, CAG_BR_IMM16, 20'h5F00D, 16'h0, 5'h0, 2'h0}, 20'h0F00D, 0, 0);
        do_br('{CAG_CLS_CALL, CAG_BR_IMM16, 20'hFFFFF, 16'h0, 5'h0, 2'h0}, 20'h0FFFF, 0, 0);
    endtask : t_immediate

    task automatic t_table;
        logic [19:0] a;
        logic [4:0]  idx;
        for (int i = 0; i < 2; i++)
        begin
            idx       = i ? 5'h1F : 5'h00;
            mem_delay = i ? 4'h5 : 4'h0;
            a         = 20'h00080 + {idx, 1'b0};
            do_br('{CAG_CLS_CALL, CAG_BR_TABLE, 20'h0, 16'h0, idx, 2'h0},
                  {4'h0, a[7:0] ^ 8'hA5, a[7:0]}, 0, a);
        end
        do_br('{CAG_CLS_BRANCH, CAG_BR_TABLE, 20'h0, 16'h0, 5'h3, 2'h0}, 0, 1, 0);
    endtask : t_table

    task automatic t_regind;
        code_seg = 4'h7;
        for (int j = 0; j < 4; j++)
        begin
            do_br('{CAG_CLS_CALL, CAG_BR_REGIND, 20'h0, 16'h0, 5'h0, j[1:0]},
                  {4'h7, reg_file[16*j+:16]}, 0, 0);
            do_br('{CAG_CLS_BRANCH, CAG_BR_REGIND, 20'h0, 16'h0, 5'h0, j[1:0]},
                  {4'h7, reg_file[15:0]}, j != 0, 0);
        end
    endtask : t_regind

    task automatic t_busy;
        mem_delay = 4'h3;
        @(posedge clk); #2;
        br_valid = 1'b1;
        br_req   = '{CAG_CLS_CALL, CAG_BR_TABLE, 20'h0, 16'h0, 5'h02, 2'h0};
        @(posedge clk); #2;
        // a request while the fetch runs must be ignored
        br_req   = '{CAG_CLS_CALL, CAG_BR_IMM20, 20'h54321, 16'h0, 5'h0, 2'h0};
        @(posedge clk); #2;
        br_valid = 1'b0;
        chk(br_busy, 1'b1);
        chk(pc_load | br_illegal, 1'b0);
        for (int n = 0; n < 12 && tbl_rd === 1'b1; n++)
        begin
            @(posedge clk); #2;
        end
        chk(pc_load, 1'b1);
        chk(pc, 20'h02184);
        @(posedge clk); #2;
        chk(pc_load | br_illegal, 1'b0);
        chk(pc, 20'h02184);
    endtask : t_busy

    task automatic t_operands;
        do_op('{CAG_OP_IMPLIED, 1'b1, CAG_REG_X, 2'h0, 16'h0, 8'h0});
        chk(op_illegal, 1'b0);
        chk(op_reg_valid, 1'b1);
        chk(op_reg_val, {8'h00, reg_file[7:0]});
        do_op('{CAG_OP_IMPLIED, 1'b0, CAG_REG_X, 2'h0, 16'h0, 8'h0});
        chk(op_illegal, 1'b1);
        do_op('{CAG_OP_NONE, 1'b0, 3'h0, 2'h0, 16'h0, 8'h0});
        chk(op_illegal, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            do_op('{CAG_OP_REG8, 1'b0, i[2:0], 2'h0, 16'h0, 8'h0});
            chk(op_reg_valid, 1'b1);
            chk(op_reg_val[7:0], reg_file[8*i+:8]);
        end
        for (int j = 0; j < 4; j++)
        begin
            do_op('{CAG_OP_REG16, 1'b0, 3'h0, j[1:0], 16'h0, 8'h0});
            chk(op_reg_valid, 1'b1);
            chk(op_reg_val, reg_file[16*j+:16]);
        end
    endtask : t_operands

    task automatic t_direct;
        // short offsets skip the reserved area and the small-ram low area
        logic [7:0]  sv [5]  = '{8'h60, 8'h1F, 8'h00, 8'hFE, 8'h80};
        logic [19:0] se [5]  = '{20'hFFE60, 20'hFFF1F, 20'hFFF00, 20'hFFEFE, 20'hFFE80};
        logic [15:0] s16 [2] = '{16'hFE60, 16'hFF1F};
        do_addr(CAG_OP_DIRECT, 16'h1234, 8'h0, 20'hF1234);
        extra_seg = 4'h3;
        do_addr(CAG_OP_DIRECT_SEG, 16'h1234, 8'h0, 20'h31234);
        extra_seg = 4'h0;
        do_addr(CAG_OP_DIRECT_SEG, 16'hFFFF, 8'h0, 20'h0FFFF);
        for (int i = 0; i < 5; i++)
            do_addr(CAG_OP_SHORT, 16'h0, sv[i], se[i]);
        do_addr(CAG_OP_SHORT_WORD, 16'h0, 8'h1E, 20'hFFF1E);
        for (int i = 0; i < 2; i++)
            do_addr(CAG_OP_SHORT, 16'h0, s16[i][7:0], {4'hF, s16[i]});
    endtask : t_direct

    // ==========================================
    // main sequence and hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            wrap_up;
        end
    end

    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        br_valid = 1'b0;
        br_req = '0;
        op_valid = 1'b0;
        op_req = '0;
        next_pc = 20'h0;
        code_seg = 4'h0;
        extra_seg = 4'h0;
        mem_delay = 4'h0;
        reg_file = 64'h8877665544332211;
        err_count = 0;
        comparisons = 0;
        cycles = 0;
        repeat (3) @(posedge clk);
        #2;
        sys_rst = 1'b0;
        chk(pc, 20'h00000);
        chk(pc_load | br_illegal | br_busy, 1'b0);
        t_relative();
        t_immediate();
        t_table();
        t_regind();
        t_busy();
        t_operands();
        t_direct();
        wrap_up();
    end

endmodule : testbench
